// ### bsd_map.svh
`ifndef BSD_MAP_SVH
`define BSD_MAP_SVH
// ==========================================================
// register offsets (byte addresses)
`define BSD_CFG_LAST_OFF 8'h0C
`define BSD_RANGE_OFF 8'h10
`define BSD_APPLIED_OFF 8'h14
`define BSD_STATE_OFF 8'h18
// ==========================================================
// field positions inside a setpoint config word
`define BSD_NORM_LSB 0
`define BSD_DVS_LSB 8
`define BSD_STBY_LSB 16
`define BSD_SPEED_LSB 24
// state word positions
`define BSD_ST_STBY_BIT 0
`define BSD_ST_DVS_LSB 1
`define BSD_ST_BUSY_LSB 4
// ==========================================================
// reset values
`define BSD_NORM_RST 5'h10
`define BSD_DVS_RST 5'h10
`define BSD_STBY_RST 5'h08
`define BSD_SPEED_RST 2'h1
`define BSD_APPLIED_RST 5'h00
`define BSD_RANGE_PRE 4'h8
// speed code used by the two bucks without a speed field
`define BSD_FIXED_SPEED 2'h1
// ==========================================================
// setpoint to millivolt mapping
`define BSD_LO_BASE_MV 11'h258
`define BSD_HI_BASE_MV 11'h44C
`define BSD_HI_TOP_MV 11'h73A
`define BSD_STEP_MV 11'h019
`define BSD_CODE_TOP 5'h1F
// ==========================================================
// timing: shortest step interval, clock rate
`define BSD_STEP_BASE_NS 2000
`define BSD_CLK_MHZ 100
`define BSD_STEP_BASE_CYC ((`BSD_STEP_BASE_NS * `BSD_CLK_MHZ + 999) / 1000)
`endif

// ### bsd_pkg.sv
package bsd_pkg;
   // ramp engine state of one buck
   typedef enum logic {BSD_HOLD, BSD_RAMP} bsd_step_t;
   // what one buck presents to its analog regulator
   typedef struct packed
   {
      logic range_high_select;
      logic [4:0] code;
      logic [10:0] millivolt;
   } bsd_buck_t;
endpackage

// ### bsd_buck_setpoint.sv
`timescale 1ns/10ps
`default_nettype none
`include "bsd_map.svh"
// Operation
// - range low maps code 0..31 to 0.600..1.375 V in 25 mV steps.
// - range high maps 0..30 to 1.100..1.850 V; code 31 saturates 1.850 V.
// - after startup range bits follow strap: fourth 1, first 0, others strap.
// - upper three range bits stay writable by software after startup, first stays 0; care on changes.
// - one range bit per buck decodes normal, standby and dvs codes alike.
// - first two bucks hold normal, dvs, standby setpoints; moves are stepped.
// - normal setpoint writes step at the programmed dvs step rate on the first two bucks, one step per 4 us on the other two.
// - standby entry and exit also step at the programmed dvs rate on the first two bucks, one step per 4 us on the other two.
// - standby condition is primary standby pin AND secondary standby pin.
// - standby selects standby code; else dvs pin picks dvs or normal.
// - speed field 00..11 gives one step per 2, 4, 8 or 16 us.
module bsd_buck_setpoint
   import bsd_pkg::*;
#(
   parameter int unsigned STEP_BASE_CYC = `BSD_STEP_BASE_CYC
)
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic primary_standby_pin,
   input wire logic secondary_standby_pin,
   input wire logic [1:0] dvs_select_pin,
   input wire logic second_power_up_strap,
   output wire bsd_buck_t [3:0] buck_out
);
   localparam int CNT_W = $clog2(STEP_BASE_CYC * 8 + 1);
   if (STEP_BASE_CYC < 1 || STEP_BASE_CYC > 4096)
   begin : g_bad_param
      $error("STEP_BASE_CYC must lie in 1..4096");
   end

   // ==========================================================
   // helpers
   function automatic logic [10:0] bsd_to_mv(input logic [4:0] code,
                                             input logic hi);
      logic [10:0] ofs;
      ofs = `BSD_STEP_MV * {6'h00, code};
      if (!hi)
         return `BSD_LO_BASE_MV + ofs;
      else if (code == `BSD_CODE_TOP)
         return `BSD_HI_TOP_MV;
      else
         return `BSD_HI_BASE_MV + ofs;
   endfunction

   function automatic logic [31:0] bsd_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [31:0] m);
      return (old & ~m) | (nw & m);
   endfunction

   // ==========================================================
   // pin synchronisers: pins are asynchronous to ref_clk
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   logic [1:0] boot_q;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
      end
      else
      begin
         pin_s1_q <= {second_power_up_strap, dvs_select_pin,
                      secondary_standby_pin, primary_standby_pin};
         pin_s2_q <= pin_s1_q;
      end
   end

   // standby event and per-buck dvs levels
   wire standby_w = pin_s2_q[0] & pin_s2_q[1];
   wire [1:0] dvs_w = pin_s2_q[3:2];
   wire strap_gnd_w = ~pin_s2_q[4]; // low pin level means grounded

   // startup counter: strap is valid once it has crossed both stages
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         boot_q <= 2'h0;
      else if (boot_q != 2'h3)
         boot_q <= boot_q + 2'h1;
   end
   wire boot_cap_w = (boot_q == 2'h2);

   // ==========================================================
   // axi4-lite slave: address and data latched independently
   logic aw_full_q;
   logic w_full_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   assign s_axi_awready = ~aw_full_q;
   assign s_axi_wready = ~w_full_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   wire do_wr_w = aw_full_q & w_full_q & ~bvalid_q;
   wire [31:0] wmask_w = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                          {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire wr_al_w = (awaddr_q[1:0] == 2'h0);
   wire wr_map_w = wr_al_w & (awaddr_q <= `BSD_STATE_OFF);
   wire wr_rng_w = do_wr_w & (awaddr_q == `BSD_RANGE_OFF);
   wire [3:0] wr_cfg_w;

   // write channel latches; a write fires once both halves are in
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         bvalid_q <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid & ~aw_full_q)
            aw_full_q <= 1'b1;
         else if (do_wr_w)
            aw_full_q <= 1'b0;
         if (s_axi_wvalid & ~w_full_q)
            w_full_q <= 1'b1;
         else if (do_wr_w)
            w_full_q <= 1'b0;
         if (do_wr_w)
            bvalid_q <= 1'b1;
         else if (s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // payload flops carry no reset; guarded by the full flags
   always_ff @(posedge ref_clk)
   begin
      if (s_axi_awvalid & ~aw_full_q)
         awaddr_q <= s_axi_awaddr;
      if (s_axi_wvalid & ~w_full_q)
      begin
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
      if (do_wr_w)
         bresp_q <= wr_map_w ? 2'h0 : 2'h2;
   end

   // ==========================================================
   // range bits
   logic [3:0] range_q;
   wire [31:0] rng_word_w = bsd_merge({28'h000_0000, range_q}, wdata_q,
                                      wmask_w);
   // strap capture once, then software owns the bits
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         range_q <= `BSD_RANGE_PRE;
      else if (boot_cap_w)
         range_q <= {1'b1, strap_gnd_w, strap_gnd_w, 1'b0};
      else if (wr_rng_w)
         range_q <= {rng_word_w[3:1], 1'b0};
   end

   // ==========================================================
   // per-buck setpoints and ramp engines
   logic [31:0] cfg_word_w [4];
   logic [4:0] applied_w [4];
   logic [3:0] busy_w;

   for (genvar i = 0; i < 4; i++)
   begin : g_buck
      logic [4:0] norm_q;
      logic [4:0] stby_q;
      logic [4:0] dvs_cfg_w;
      logic [1:0] spd_w;
      logic [4:0] tgt_w;
      logic [4:0] code_q;
      logic [CNT_W-1:0] cnt_q;
      logic [CNT_W-1:0] intv_w;
      bsd_step_t st_q;
      bsd_buck_t out_q;
      logic [31:0] wr_word_w;

      assign wr_cfg_w[i] = do_wr_w & (awaddr_q == 8'(i * 4));
      assign wr_word_w = bsd_merge(cfg_word_w[i], wdata_q, wmask_w);
      assign cfg_word_w[i] = (32'(norm_q) << `BSD_NORM_LSB)
                           | (32'(dvs_cfg_w) << `BSD_DVS_LSB)
                           | (32'(stby_q) << `BSD_STBY_LSB)
                           | (32'(spd_w) << `BSD_SPEED_LSB);
      // one step interval; doubles per speed code
      assign intv_w = CNT_W'(STEP_BASE_CYC) << spd_w;

      // normal and standby setpoints, all four bucks
      always_ff @(posedge ref_clk)
      begin
         if (sys_rst)
         begin
            norm_q <= `BSD_NORM_RST;
            stby_q <= `BSD_STBY_RST;
         end
         else if (wr_cfg_w[i])
         begin
            norm_q <= wr_word_w[`BSD_NORM_LSB +: 5];
            stby_q <= wr_word_w[`BSD_STBY_LSB +: 5];
         end
      end

      if (i < 2)
      begin : g_dvs
         logic [4:0] dvs_q;
         logic [1:0] spd_q;
         always_ff @(posedge ref_clk)
         begin
            if (sys_rst)
            begin
               dvs_q <= `BSD_DVS_RST;
               spd_q <= `BSD_SPEED_RST;
            end
            else if (wr_cfg_w[i])
            begin
               dvs_q <= wr_word_w[`BSD_DVS_LSB +: 5];
               spd_q <= wr_word_w[`BSD_SPEED_LSB +: 2];
            end
         end
         assign dvs_cfg_w = dvs_q;
         assign spd_w = spd_q;
         // standby beats the dvs pin
         assign tgt_w = standby_w ? stby_q
                      : (dvs_w[i] ? dvs_q : norm_q);
      end
      else
      begin : g_fix
         // no dvs pin here: 4 us fixed stepping
         assign dvs_cfg_w = 5'h00;
         assign spd_w = `BSD_FIXED_SPEED;
         assign tgt_w = standby_w ? stby_q : norm_q;
      end

      // ramp: one code per interval, the whole way to the target;
      // a target change mid-ramp just redirects the next step
      always_ff @(posedge ref_clk)
      begin
         if (sys_rst)
         begin
            st_q <= BSD_HOLD;
            cnt_q <= '0;
            code_q <= `BSD_APPLIED_RST;
         end
         else
         begin
            case (st_q)
               BSD_HOLD:
               begin
                  cnt_q <= '0;
                  if (code_q != tgt_w)
                     st_q <= BSD_RAMP;
               end
               BSD_RAMP:
               begin
                  if (cnt_q == intv_w - CNT_W'(1))
                  begin
                     cnt_q <= '0;
                     if (code_q < tgt_w)
                        code_q <= code_q + 5'h01;
                     else if (code_q > tgt_w)
                        code_q <= code_q - 5'h01;
                     else
                        st_q <= BSD_HOLD;
                  end
                  else
                     cnt_q <= cnt_q + CNT_W'(1);
               end
               default:
                  st_q <= BSD_HOLD;
            endcase
         end
      end

      // analog-facing view, registered; one range bit for every code
      always_ff @(posedge ref_clk)
      begin
         if (sys_rst)
            out_q <= '0;
         else
         begin
            out_q.range_high_select <= range_q[i];
            out_q.code <= code_q;
            out_q.millivolt <= bsd_to_mv(code_q, range_q[i]);
         end
      end
      assign buck_out[i] = out_q;
      assign applied_w[i] = code_q;
      assign busy_w[i] = (st_q == BSD_RAMP);
   end

   // ==========================================================
   // read path
   wire rd_cfg_w = (s_axi_araddr <= `BSD_CFG_LAST_OFF);
   wire rd_al_w = (s_axi_araddr[1:0] == 2'h0);
   wire [31:0] applied_word_w = {3'h0, applied_w[3], 3'h0, applied_w[2],
                                 3'h0, applied_w[1], 3'h0, applied_w[0]};
   wire [31:0] state_word_w = (32'(standby_w) << `BSD_ST_STBY_BIT)
                            | (32'(dvs_w) << `BSD_ST_DVS_LSB)
                            | (32'(busy_w) << `BSD_ST_BUSY_LSB);
   wire [31:0] rd_word_w =
      !rd_al_w ? 32'h0000_0000
      : rd_cfg_w ? cfg_word_w[s_axi_araddr[3:2]]
      : (s_axi_araddr == `BSD_RANGE_OFF) ? {28'h000_0000, range_q}
      : (s_axi_araddr == `BSD_APPLIED_OFF) ? applied_word_w
      : (s_axi_araddr == `BSD_STATE_OFF) ? state_word_w
      : 32'h0000_0000;
   wire rd_map_w = rd_al_w & (s_axi_araddr <= `BSD_STATE_OFF);

   // read answer one cycle after the address is taken
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'h0;
      end
      else if (s_axi_arvalid & ~rvalid_q)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word_w;
         rresp_q <= rd_map_w ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // ==========================================================
   // checks
   // output flops hold reset zeros until the first edge after release,
   // so the checks stay quiet until they carry real values
   logic [1:0] chk_live_q;
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         chk_live_q <= 2'h0;
      else
         chk_live_q <= {chk_live_q[0], 1'b1};
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst || !chk_live_q[1]);

   AST_MV_LOW: assert property (!buck_out[1].range_high_select |->
      buck_out[1].millivolt == `BSD_LO_BASE_MV
         + `BSD_STEP_MV * {6'h00, buck_out[1].code})
      else $error("low range millivolt mismatch");
   AST_MV_TOP: assert property (buck_out[1].range_high_select
      && buck_out[1].code == `BSD_CODE_TOP
      |-> buck_out[1].millivolt == `BSD_HI_TOP_MV)
      else $error("high range top code not saturated");
   AST_FIRST_LOW: assert property (!range_q[0])
      else $error("first buck range bit set");
   AST_STRAP: assert property (boot_cap_w |=> range_q[3]
      && range_q[1] == $past(strap_gnd_w) && range_q[2] == range_q[1])
      else $error("range bits not taken from strap");
   AST_RANGE_WR: assert property (wr_rng_w && !boot_cap_w
      |=> range_q[3:1] == $past(rng_word_w[3:1]))
      else $error("range write lost");
   AST_SEL_STBY: assert property (pin_s2_q[0] && pin_s2_q[1]
      |-> g_buck[0].tgt_w == g_buck[0].stby_q)
      else $error("standby not selected");
   AST_SEL_DVS: assert property (!standby_w && dvs_w[1]
      |-> g_buck[1].tgt_w == g_buck[1].g_dvs.dvs_q)
      else $error("dvs setpoint not selected");
   AST_ONE_STEP: assert property ($changed(applied_w[0])
      |-> applied_w[0] == $past(applied_w[0]) + 5'h01
       || applied_w[0] == $past(applied_w[0]) - 5'h01)
      else $error("applied code jumped");
   AST_STEP_TIME: assert property ($changed(applied_w[1])
      |-> $past(g_buck[1].cnt_q) == $past(g_buck[1].intv_w) - CNT_W'(1))
      else $error("step taken before interval ended");
   AST_NO_RAMP_IDLE: assert property (g_buck[0].st_q == BSD_HOLD
      |=> $stable(applied_w[0]))
      else $error("code moved while holding");

   CVR_STBY_RAMP: cover property (standby_w ##1 busy_w[0] [*4]);
   CVR_DVS_STEP: cover property (dvs_w[0] ##[1:1000] $changed(applied_w[0]));
   CVR_AXI_WR: cover property (do_wr_w && wr_cfg_w[1]);
endmodule
`default_nettype wire

// ### bsd_host_pins.sv
`timescale 1ns/10ps
`default_nettype none
// ==========
// processor side of the standby, dvs and strap pins
module bsd_host_pins
(
   input wire logic ref_clk,
   output logic primary_standby_pin,
   output logic secondary_standby_pin,
   output logic [1:0] dvs_select_pin,
   output logic second_power_up_strap
);
   // strap starts grounded; set_strap can change it, but it only counts at startup
   initial
   begin
      primary_standby_pin = 1'b0;
      secondary_standby_pin = 1'b0;
      dvs_select_pin = 2'h0;
      second_power_up_strap = 1'b0;
   end
   // pins move just after an edge, levels held until the next call
   task automatic drive(input logic p, input logic s, input logic [1:0] d);
      @(posedge ref_clk);
      primary_standby_pin <= p;
      secondary_standby_pin <= s;
      dvs_select_pin <= d;
   endtask
   // strap level; only taken again after the next reset
   task automatic set_strap(input logic v);
      @(posedge ref_clk);
      second_power_up_strap <= v;
   endtask
endmodule
`default_nettype wire

// ### test_buck_setpoint_dvs_select.sv
`timescale 1ns/10ps
`default_nettype none
`include "bsd_map.svh"
module test_buck_setpoint_dvs_select
   import bsd_pkg::*;
;
   // ==========
   // short step base keeps every ramp brief
   localparam int BASE = 2;
   logic ref_clk, sys_rst, awv, wv, bry, arv, rry;
   logic awr, wrd, bv, ar, rv, prim, sec, strap;
   logic [7:0] awa, ara;
   logic [31:0] wd, rdat, rd;
   logic [1:0] br, rr, rs, dvs;
   logic [3:0] ws;
   bsd_buck_t [3:0] bo, bo_s;
   logic awr_s, wr_s, bv_s, ar_s, rv_s;
   logic [1:0] br_s, rr_s;
   logic [31:0] rd_s;
   logic [4:0] e0, e1;
   logic [2:0] pat [6];
   int errors = 0;
   int n_tests = 0;

   bsd_buck_setpoint #(.STEP_BASE_CYC(BASE)) uut (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
      .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(ar), .s_axi_rdata(rdat),
      .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .primary_standby_pin(prim), .secondary_standby_pin(sec),
      .dvs_select_pin(dvs), .second_power_up_strap(strap),
      .buck_out(bo));
   bsd_host_pins host (.ref_clk(ref_clk), .primary_standby_pin(prim),
      .secondary_standby_pin(sec), .dvs_select_pin(dvs),
      .second_power_up_strap(strap));

   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;
   // mid-cycle copy: what the next rising edge sees, free of races
   always @(negedge ref_clk)
   begin
      awr_s = awr;
      wr_s = wrd;
      bv_s = bv;
      br_s = br;
      ar_s = ar;
      rv_s = rv;
      rr_s = rr;
      rd_s = rdat;
      bo_s = bo;
   end
   // ==========
   // compare, bus tasks
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge ref_clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge ref_clk);
         if (!aw_ok && awr_s)
         begin
            aw_ok = 1'b1;
            awv <= 1'b0;
         end
         if (!w_ok && wr_s)
         begin
            w_ok = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge ref_clk); while (!bv_s);
      r = br_s;
      bry <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      @(posedge ref_clk);
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge ref_clk); while (!ar_s);
      arv <= 1'b0;
      do @(posedge ref_clk); while (!rv_s);
      d = rd_s;
      r = rr_s;
      rry <= 1'b0;
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] d);
      wr(a, d, rs);
      chk(32'(rs), 32'h0000_0000, "write resp");
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      rd_reg(a, rd, rs);
      chk(rd, e, "read data");
      chk(32'(rs), 32'h0000_0000, "read resp");
   endtask
   // expected millivolts, upper range clipped at its top
   function automatic logic [31:0] mv(input logic hi, input logic [4:0] c);
      logic [31:0] v;
      v = (hi ? 32'h0000_044C : 32'h0000_0258) + 32'h0000_0019 * c;
      if (v > 32'h0000_073A)
         v = 32'h0000_073A;
      return v;
   endfunction
   task automatic settle(input int b, input logic [4:0] c);
      int n;
      n = 0;
      while (bo_s[b].code !== c && n < 2000)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk(32'(bo_s[b].code), 32'(c), "settled code");
   endtask
   // gap between code moves and the size of each move
   task automatic steps(input int b, input int n, input int gap,
      input logic up);
      logic [4:0] p;
      int c;
      p = bo_s[b].code;
      c = 0;
      while (bo_s[b].code === p && c < 2000)
      begin
         @(posedge ref_clk);
         c++;
      end
      repeat (n)
      begin
         p = bo_s[b].code;
         c = 0;
         while (bo_s[b].code === p && c < 100)
         begin
            @(posedge ref_clk);
            c++;
         end
         chk(32'(c), 32'(gap), "step gap");
         chk(32'(bo_s[b].code), 32'(up ? p + 5'h01 : p - 5'h01), "step");
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========
   // watchdog, far beyond the thousand or so cycles the tests need
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_of_test();
   end
   initial
   begin
      pat = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h6, 3'h7};
      sys_rst = 1'b1;
      {awv, wv, bry, arv, rry} = 5'h00;
      awa = 8'h00;
      ara = 8'h00;
      wd = 32'h0000_0000;
      ws = 4'hF;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      settle(0, 5'h10);
      settle(3, 5'h10);
      rchk(`BSD_RANGE_OFF, 32'h0000_000E);
      chk(32'(bo_s[0].millivolt), mv(1'b0, 5'h10), "low mv");
      chk(32'(bo_s[1].millivolt), mv(1'b1, 5'h10), "high mv");
      rchk(8'h00, 32'h0108_1010);
      $display("test startup done");
      wchk(`BSD_RANGE_OFF, 32'h0000_000F);
      rchk(`BSD_RANGE_OFF, 32'h0000_000E);
      wchk(8'h04, 32'h001E_001F);
      settle(1, 5'h1F);
      chk(32'(bo_s[1].millivolt), mv(1'b1, 5'h1F), "top mv");
      wchk(`BSD_RANGE_OFF, 32'h0000_000C);
      rchk(`BSD_RANGE_OFF, 32'h0000_000C);
      chk(32'(bo_s[1].millivolt), mv(1'b0, 5'h1F), "range mv");
      $display("test ranges done");
      // normal writes ramp at each speed, alternating up and down
      for (int s = 0; s < 4; s++)
      begin
         wchk(8'h00, {6'h00, s[1:0], 8'h08, 8'h10, 3'h0,
            s[0] ? 5'h10 : 5'h14});
         steps(0, 3, BASE << s, !s[0]);
         settle(0, s[0] ? 5'h10 : 5'h14);
      end
      wchk(8'h08, 32'h0000_0012);
      steps(2, 1, BASE << 1, 1'b1);
      $display("test stepping done");
      // selection table on both dvs bucks, buck two in low range
      wchk(8'h00, 32'h0009_0502);
      for (int i = 0; i < 6; i++)
      begin
         host.drive(pat[i][2], pat[i][1], {2{pat[i][0]}});
         e0 = (pat[i][2] && pat[i][1]) ? 5'h09 : pat[i][0] ? 5'h05 : 5'h02;
         e1 = (pat[i][2] && pat[i][1]) ? 5'h1E : pat[i][0] ? 5'h00 : 5'h1F;
         settle(0, e0);
         settle(1, e1);
         chk(32'(bo_s[1].millivolt), mv(1'b0, e1), "sel mv");
      end
      wchk(8'h00, 32'h0309_0502);
      host.drive(1'b0, 1'b0, 2'h0);
      steps(0, 2, BASE << 3, 1'b0);
      settle(0, 5'h02);
      $display("test selection done");
      rd_reg(8'h1C, rd, rs);
      chk(rd, 32'h0000_0000, "unmapped data");
      chk(32'(rs), 32'h0000_0002, "unmapped resp");
      wr(8'h02, 32'h0000_0001, rs);
      chk(32'(rs), 32'h0000_0002, "unaligned resp");
      wchk(`BSD_APPLIED_OFF, 32'h0000_0000);
      // only byte zero enabled: upper fields must keep their values
      ws <= 4'h1;
      wchk(8'h00, 32'hFFFF_FF02);
      ws <= 4'hF;
      rchk(8'h00, 32'h0309_0502);
      settle(2, 5'h12);
      settle(3, 5'h10);
      rchk(`BSD_APPLIED_OFF, 32'h1012_1F02);
      // let every engine fall back to holding
      repeat (40) @(posedge ref_clk);
      rchk(`BSD_STATE_OFF, 32'h0000_0000);
      $display("test bus errors done");
      // strap left open across a second reset
      host.set_strap(1'b1);
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rchk(`BSD_RANGE_OFF, 32'h0000_0008);
      chk(32'(bo_s[2].range_high_select), 32'h0000_0000,
         "open strap");
      $display("test strap open done");
      end_of_test();
   end
endmodule
`default_nettype wire
